/* File: hw/sccs_map.svh */
`ifndef SCCS_MAP_SVH
`define SCCS_MAP_SVH
// Register offsets on the plain port
`define SCCS_ADDR_OWN_BUS_IDENTITY_REGISTER 8'h00
`define SCCS_ADDR_CONTROL 8'h01
`define SCCS_ADDR_TIMEOUT 8'h02
`define SCCS_ADDR_TARGET_ID 8'h04
`define SCCS_ADDR_XFER_CNT 8'h05
`define SCCS_ADDR_STATUS 8'h17
`define SCCS_ADDR_AUX 8'h1f
`define SCCS_ADDR_COMMAND 8'h18
// Opcodes
`define SCCS_OP_RESET 8'h00
`define SCCS_OP_ABORT 8'h01
`define SCCS_OP_ASSERT_ATN 8'h02
`define SCCS_OP_NEGATE_ACK 8'h03
`define SCCS_OP_DISCONNECT 8'h04
`define SCCS_OP_SEL_ATN 8'h06
`define SCCS_OP_SET_IDI 8'h0f
// Status codes
`define SCCS_ST_RESET 8'h00
`define SCCS_ST_RESET_ADV 8'h01
`define SCCS_ST_SEL_OK 8'h11
`define SCCS_ST_ABORT_OK 8'h10
`define SCCS_ST_PAUSED 8'h20
`define SCCS_ST_TERMINATED 8'h42
`define SCCS_ST_SVC_REQ 8'h80
// Field positions
`define SCCS_OWN_ADV_BIT 3
`define SCCS_CTRL_IDI_BIT 0
`define SCCS_CTRL_HSP_BIT 1
// Reset values
`define SCCS_CONTROL_RST 8'h00
`define SCCS_TIMEOUT_RST 8'h20
// Timing: selection abort waits 200 us at 100 MHz unless the target answers with BSY
`define SCCS_ABORT_WAIT_US 200
`define SCCS_CLK_MHZ 100
`define SCCS_ABORT_WAIT_CYC (`SCCS_ABORT_WAIT_US * `SCCS_CLK_MHZ)
// Timeout unit per period count, in cycles
`define SCCS_TIMEOUT_UNIT_CYC 800
// Arbitration delay in cycles
`define SCCS_ARB_CYC 24
`endif

/* File: hw/sccs_pkg.sv */
package sccs_pkg;
  // Connection state of the controller
  typedef enum logic [1:0] {
    SCCS_DISC,
    SCCS_TARGET,
    SCCS_INIT
  } sccs_conn_e;
  // Selection sequencer states
  typedef enum logic [2:0] {
    SCCS_SQ_IDLE,
    SCCS_SQ_ARB,
    SCCS_SQ_SEL,
    SCCS_SQ_ABORT,
    SCCS_SQ_TGT_ABORT
  } sccs_seq_e;
endpackage : sccs_pkg

/* File: hw/sccs_down_counter.sv */
`timescale 1ns/1ps
// Loadable down counter with a sticky expiry flag
module sccs_down_counter #(
  parameter int W = 24
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic run,
  output logic expired
);
  logic [W-1:0] cnt_reg;
  // Count down while running; load wins over counting
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      cnt_reg <= '0;
      expired <= 1'b0;
    end
    else if (load)
    begin
      cnt_reg <= load_val;
      expired <= 1'b0;
    end
    else if (run && cnt_reg != '0)
    begin
      cnt_reg <= cnt_reg - 1'b1;
      expired <= (cnt_reg == {{(W-1){1'b0}}, 1'b1});
    end
  end
endmodule : sccs_down_counter

/* File: hw/sccs_sequencer.sv */
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "sccs_map.svh"
module sccs_sequencer #(
  parameter int ABORT_WAIT_CYC = `SCCS_ABORT_WAIT_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic hardware_reset_pin,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic irq,
  // SCSI bus, active high internally
  input wire logic bsy_in,
  input wire logic sel_in,
  input wire logic arb_lost,
  input wire logic msg_out_last_byte,
  input wire logic identify_sent,
  input wire logic held_ack_event,
  input wire logic host_parity_err,
  input wire logic xfer_byte_done,
  input wire logic sel_xfer_active,
  input wire logic fifo_empty,
  output logic bsy_oe,
  output logic sel_oe,
  output logic atn_oe,
  output logic ack_oe,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic transfer_request_line
);
  // Connection and sequencer state
  sccs_pkg::sccs_conn_e conn_reg, conn_next;
  sccs_pkg::sccs_seq_e seq_reg, seq_next;
  // Software registers
  logic [7:0] own_bus_identity_register_reg;
  logic [7:0] control_reg;
  logic [7:0] timeout_reg;
  logic [2:0] target_id_reg;
  logic [23:0] xfer_cnt_reg;
  logic [7:0] status_reg;
  logic advanced_reg;
  // Pending command, taken one edge after the write
  logic [7:0] cmd_reg;
  logic cmd_pend_reg;
  logic [5:0] arb_cnt_reg;
  // Soft reset: reset opcode only; the pin acts through full_reset
  wire soft_reset = cmd_pend_reg && cmd_reg == `SCCS_OP_RESET;
  // Decoded opcodes qualified by state
  wire cmd_abort = cmd_pend_reg && cmd_reg == `SCCS_OP_ABORT;
  wire abort_ok = cmd_abort && conn_reg != sccs_pkg::SCCS_INIT;
  wire cmd_disc = cmd_pend_reg && cmd_reg == `SCCS_OP_DISCONNECT;
  wire disc_ok = cmd_disc && conn_reg != sccs_pkg::SCCS_DISC;
  wire atn_ok = cmd_pend_reg && cmd_reg == `SCCS_OP_ASSERT_ATN && conn_reg == sccs_pkg::SCCS_INIT;
  wire nack_ok = cmd_pend_reg && cmd_reg == `SCCS_OP_NEGATE_ACK && conn_reg == sccs_pkg::SCCS_INIT;
  wire idi_ok = cmd_pend_reg && cmd_reg == `SCCS_OP_SET_IDI && sel_xfer_active;
  wire sel_ok = cmd_pend_reg && cmd_reg == `SCCS_OP_SEL_ATN && conn_reg == sccs_pkg::SCCS_DISC
    && seq_reg == sccs_pkg::SCCS_SQ_IDLE;
  wire bus_free = !bsy_in && !sel_in;
  // Register write decode
  wire wr_own = wr && addr == `SCCS_ADDR_OWN_BUS_IDENTITY_REGISTER;
  wire wr_ctrl = wr && addr == `SCCS_ADDR_CONTROL;
  wire wr_tmo = wr && addr == `SCCS_ADDR_TIMEOUT;
  wire wr_tid = wr && addr == `SCCS_ADDR_TARGET_ID;
  wire wr_cnt = wr && addr == `SCCS_ADDR_XFER_CNT;
  wire wr_cmd = wr && addr == `SCCS_ADDR_COMMAND;
  wire rd_status = rd && addr == `SCCS_ADDR_STATUS;
  // Timers
  logic sel_tmo_exp;
  logic abort_exp;
  wire sel_tmo_load = seq_reg == sccs_pkg::SCCS_SQ_ARB && seq_next == sccs_pkg::SCCS_SQ_SEL;
  wire abort_load = seq_reg != sccs_pkg::SCCS_SQ_ABORT && seq_next == sccs_pkg::SCCS_SQ_ABORT;
  // Timeout period register scaled to cycles; zero disables timeout
  wire [23:0] tmo_cycles = 24'(timeout_reg * `SCCS_TIMEOUT_UNIT_CYC);
  wire tmo_enabled = timeout_reg != 8'h00;
  sccs_down_counter #(.W(24)) u_sel_tmo (
    .mclk(mclk),
    .rst_n(rst_n),
    .load(sel_tmo_load),
    .load_val(tmo_cycles),
    .run(seq_reg == sccs_pkg::SCCS_SQ_SEL && tmo_enabled),
    .expired(sel_tmo_exp)
  );
  sccs_down_counter #(.W(24)) u_abort_wait (
    .mclk(mclk),
    .rst_n(rst_n),
    .load(abort_load),
    .load_val(24'(ABORT_WAIT_CYC)),
    .run(seq_reg == sccs_pkg::SCCS_SQ_ABORT),
    .expired(abort_exp)
  );
  // Interrupt status to post this cycle
  logic post;
  logic [7:0] post_code;
  // Sequencer next state
  always_comb
  begin
    seq_next = seq_reg;
    conn_next = conn_reg;
    post = 1'b0;
    post_code = 8'h00;
    if (soft_reset)
    begin
      seq_next = sccs_pkg::SCCS_SQ_IDLE;
      conn_next = sccs_pkg::SCCS_DISC;
      post = 1'b1;
      post_code = own_bus_identity_register_reg[`SCCS_OWN_ADV_BIT] ? `SCCS_ST_RESET_ADV : `SCCS_ST_RESET;
    end
    else if (disc_ok)
    begin
      seq_next = sccs_pkg::SCCS_SQ_IDLE;
      conn_next = sccs_pkg::SCCS_DISC;
    end
    else
    begin
      case (seq_reg)
        sccs_pkg::SCCS_SQ_IDLE:
        begin
          if (sel_ok)
            seq_next = sccs_pkg::SCCS_SQ_ARB;
          else if (abort_ok && conn_reg == sccs_pkg::SCCS_TARGET)
            seq_next = sccs_pkg::SCCS_SQ_TGT_ABORT;
        end
        sccs_pkg::SCCS_SQ_ARB:
        begin
          if (abort_ok)
          begin
            seq_next = sccs_pkg::SCCS_SQ_IDLE;
            post = 1'b1;
            post_code = `SCCS_ST_PAUSED;
          end
          else if (sel_in)
          begin
            seq_next = sccs_pkg::SCCS_SQ_IDLE;
            post = 1'b1;
            post_code = `SCCS_ST_SVC_REQ;
          end
          else if (arb_cnt_reg == 6'h00 && !arb_lost)
            seq_next = sccs_pkg::SCCS_SQ_SEL;
        end
        sccs_pkg::SCCS_SQ_SEL:
        begin
          if (bsy_in)
          begin
            seq_next = sccs_pkg::SCCS_SQ_IDLE;
            conn_next = sccs_pkg::SCCS_INIT;
            post = 1'b1;
            post_code = `SCCS_ST_SEL_OK;
          end
          else if (sel_tmo_exp || abort_ok)
            seq_next = sccs_pkg::SCCS_SQ_ABORT;
        end
        sccs_pkg::SCCS_SQ_ABORT:
        begin
          if (bsy_in)
          begin
            seq_next = sccs_pkg::SCCS_SQ_IDLE;
            conn_next = sccs_pkg::SCCS_INIT;
            post = 1'b1;
            post_code = `SCCS_ST_SEL_OK;
          end
          else if (abort_exp)
          begin
            seq_next = sccs_pkg::SCCS_SQ_IDLE;
            post = 1'b1;
            post_code = sel_tmo_exp ? `SCCS_ST_TERMINATED : `SCCS_ST_PAUSED;
          end
        end
        sccs_pkg::SCCS_SQ_TGT_ABORT:
        begin
          // Wait for the FIFO to drain; state stays target
          if (fifo_empty)
          begin
            seq_next = sccs_pkg::SCCS_SQ_IDLE;
            post = 1'b1;
            post_code = `SCCS_ST_ABORT_OK;
          end
        end
        default:
          seq_next = sccs_pkg::SCCS_SQ_IDLE;
      endcase
    end
  end
  wire full_reset = !rst_n || !hardware_reset_pin;
  // State registers
  always_ff @(posedge mclk)
  begin
    if (full_reset)
    begin
      seq_reg <= sccs_pkg::SCCS_SQ_IDLE;
      conn_reg <= sccs_pkg::SCCS_DISC;
    end
    else
    begin
      seq_reg <= seq_next;
      conn_reg <= conn_next;
    end
  end
  // Command capture; executed on the following edge
  always_ff @(posedge mclk)
  begin
    if (full_reset)
    begin
      cmd_reg <= 8'h00;
      cmd_pend_reg <= 1'b0;
    end
    else
    begin
      cmd_pend_reg <= wr_cmd;
      if (wr_cmd)
        cmd_reg <= wdata;
    end
  end
  // Arbitration delay counter
  always_ff @(posedge mclk)
  begin
    if (full_reset || seq_reg != sccs_pkg::SCCS_SQ_ARB)
      arb_cnt_reg <= 6'(`SCCS_ARB_CYC);
    else if (arb_cnt_reg != 6'h00)
      arb_cnt_reg <= arb_cnt_reg - 6'h01;
  end
  // Configuration registers; soft reset samples the identity register
  always_ff @(posedge mclk)
  begin
    if (full_reset)
    begin
      own_bus_identity_register_reg <= 8'h00;
      timeout_reg <= `SCCS_TIMEOUT_RST;
      target_id_reg <= 3'h0;
      advanced_reg <= 1'b0;
    end
    else
    begin
      if (wr_own)
        own_bus_identity_register_reg <= wdata;
      if (wr_tmo)
        timeout_reg <= wdata;
      if (wr_tid)
        target_id_reg <= wdata[2:0];
      if (soft_reset)
        advanced_reg <= own_bus_identity_register_reg[`SCCS_OWN_ADV_BIT];
    end
  end
  // Control register; set command wins over a software write
  always_ff @(posedge mclk)
  begin
    if (full_reset || soft_reset)
      control_reg <= `SCCS_CONTROL_RST;
    else if (idi_ok)
      control_reg[`SCCS_CTRL_IDI_BIT] <= 1'b1;
    else if (wr_ctrl)
      control_reg <= wdata;
  end
  // Transfer count: decrements per byte, holds residue after abort
  always_ff @(posedge mclk)
  begin
    if (full_reset)
      xfer_cnt_reg <= 24'h000000;
    else if (wr_cnt)
      xfer_cnt_reg <= {16'h0000, wdata};
    else if (xfer_byte_done && xfer_cnt_reg != 24'h000000)
      xfer_cnt_reg <= xfer_cnt_reg - 24'h000001;
  end
  // Status and interrupt: a new post wins over the read-clear
  always_ff @(posedge mclk)
  begin
    if (full_reset)
    begin
      status_reg <= 8'h00;
      irq <= 1'b0;
    end
    else if (post)
    begin
      status_reg <= post_code;
      irq <= 1'b1;
    end
    else if (rd_status)
      irq <= 1'b0;
  end
  // Read data mux
  logic [7:0] rdata_next;
  always_comb
  begin
    case (addr)
      `SCCS_ADDR_OWN_BUS_IDENTITY_REGISTER: rdata_next = own_bus_identity_register_reg;
      `SCCS_ADDR_CONTROL: rdata_next = control_reg;
      `SCCS_ADDR_TIMEOUT: rdata_next = timeout_reg;
      `SCCS_ADDR_TARGET_ID: rdata_next = {5'h00, target_id_reg};
      `SCCS_ADDR_XFER_CNT: rdata_next = xfer_cnt_reg[7:0];
      `SCCS_ADDR_STATUS: rdata_next = status_reg;
      `SCCS_ADDR_AUX: rdata_next = {irq, seq_reg != sccs_pkg::SCCS_SQ_IDLE, 4'h0, advanced_reg, 1'b0};
      default: rdata_next = 8'h00;
    endcase
  end
  always_ff @(posedge mclk)
  begin
    if (full_reset)
      rdata <= 8'h00;
    else
      rdata <= rd ? rdata_next : 8'h00;
  end
  // Bus drive next values
  wire in_sel = seq_next == sccs_pkg::SCCS_SQ_SEL;
  wire in_abort = seq_next == sccs_pkg::SCCS_SQ_ABORT;
  wire in_arb = seq_next == sccs_pkg::SCCS_SQ_ARB && seq_reg == sccs_pkg::SCCS_SQ_ARB;
  wire [7:0] own_bit = 8'h01 << own_bus_identity_register_reg[2:0];
  wire [7:0] tgt_bit = 8'h01 << target_id_reg;
  // ATN next: set by command or selection, cleared on listed events
  logic atn_next;
  always_comb
  begin
    atn_next = atn_oe;
    if (in_sel && seq_reg == sccs_pkg::SCCS_SQ_ARB)
      atn_next = 1'b1;
    else if (atn_ok)
      atn_next = 1'b1;
    if (msg_out_last_byte || identify_sent || (bus_free && conn_reg != sccs_pkg::SCCS_DISC))
      atn_next = 1'b0;
    if (conn_next == sccs_pkg::SCCS_DISC && !in_sel && !in_abort)
      atn_next = 1'b0;
  end
  // ACK next: held events set it, the command or auto-negation clears
  logic ack_next;
  always_comb
  begin
    ack_next = ack_oe;
    if (held_ack_event)
      ack_next = 1'b1;
    else if (nack_ok)
      ack_next = 1'b0;
    else if (xfer_byte_done && !host_parity_err)
      ack_next = 1'b0;
    if (conn_next == sccs_pkg::SCCS_DISC)
      ack_next = 1'b0;
  end
  // Bus output registers
  always_ff @(posedge mclk)
  begin
    if (full_reset || soft_reset || disc_ok)
    begin
      bsy_oe <= 1'b0;
      sel_oe <= 1'b0;
      atn_oe <= 1'b0;
      ack_oe <= 1'b0;
      data_out <= 8'h00;
      data_oe <= 1'b0;
      transfer_request_line <= 1'b0;
    end
    else
    begin
      bsy_oe <= in_arb || (seq_next == sccs_pkg::SCCS_SQ_ARB);
      sel_oe <= in_sel || in_abort;
      atn_oe <= atn_next;
      ack_oe <= ack_next;
      data_out <= in_sel ? (own_bit | tgt_bit) : (seq_next == sccs_pkg::SCCS_SQ_ARB ? own_bit : 8'h00);
      data_oe <= in_sel || seq_next == sccs_pkg::SCCS_SQ_ARB;
      // Data request is never raised; held low in every state
      transfer_request_line <= 1'b0;
    end
  end
  // A select in arbitration that sees a selection drops to idle and posts the service request with irq
  AST_SEL_DROP: assert property (@(posedge mclk) disable iff (!rst_n || !hardware_reset_pin)
    (seq_reg == sccs_pkg::SCCS_SQ_ARB && !soft_reset && !disc_ok && !abort_ok && sel_in)
    |=> (seq_reg == sccs_pkg::SCCS_SQ_IDLE && status_reg == `SCCS_ST_SVC_REQ && irq))
    else $error("selection during arbitration not dropped");
  AST_ABORT_ID_OFF: assert property (@(posedge mclk) disable iff (!rst_n || !hardware_reset_pin)
    (seq_reg == sccs_pkg::SCCS_SQ_ABORT) |-> (sel_oe && !data_oe))
    else $error("abort sequence drives ids or lost SEL");
  AST_RESET_CODE: assert property (@(posedge mclk) disable iff (!rst_n || !hardware_reset_pin)
    soft_reset |=> (irq && conn_reg == sccs_pkg::SCCS_DISC && status_reg[7:1] == 7'h00))
    else $error("reset opcode result wrong");
  AST_DISC_RELEASE: assert property (@(posedge mclk) disable iff (!rst_n || !hardware_reset_pin)
    (disc_ok && !soft_reset) |=> (!bsy_oe && !sel_oe && !atn_oe && !ack_oe && !data_oe
    && conn_reg == sccs_pkg::SCCS_DISC))
    else $error("disconnect did not release bus");
  AST_ATN_ONLY_INIT: assert property (@(posedge mclk) disable iff (!rst_n || !hardware_reset_pin)
    (cmd_pend_reg && cmd_reg == `SCCS_OP_ASSERT_ATN && conn_reg == sccs_pkg::SCCS_DISC
    && seq_reg == sccs_pkg::SCCS_SQ_IDLE) |=> !atn_oe)
    else $error("attention asserted while not initiator");
  AST_SEL_ATN: assert property (@(posedge mclk) disable iff (!rst_n || !hardware_reset_pin)
    (seq_reg == sccs_pkg::SCCS_SQ_SEL) |-> (atn_oe && sel_oe && !bsy_oe))
    else $error("selection signals wrong");
  AST_SEL_OK: assert property (@(posedge mclk) disable iff (!rst_n || !hardware_reset_pin)
    (seq_reg == sccs_pkg::SCCS_SQ_SEL && bsy_in && !soft_reset && !disc_ok)
    |=> (conn_reg == sccs_pkg::SCCS_INIT && !sel_oe && status_reg == `SCCS_ST_SEL_OK))
    else $error("target response not completed");
  AST_ARB_CANCEL: assert property (@(posedge mclk) disable iff (!rst_n || !hardware_reset_pin)
    (seq_reg == sccs_pkg::SCCS_SQ_ARB && abort_ok && !soft_reset && !disc_ok)
    |=> (!sel_oe && seq_reg == sccs_pkg::SCCS_SQ_IDLE))
    else $error("abort before win not immediate");
endmodule : sccs_sequencer

/* File: verif/sccs_bus_model.sv */
`timescale 1ns/1ps
// Behavioural target on the far side of the bus: answers its own selection with BSY
module sccs_bus_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sel_oe,
  input wire logic data_oe,
  input wire logic [7:0] data_out,
  input wire logic [2:0] my_id,
  input wire logic [15:0] delay,
  input wire logic free,
  output logic bsy_in
);
  logic [15:0] cnt; // Cycles since selection began
  logic armed; // Own identity bit was seen with SEL

  // Respond after delay cycles of SEL; a zero delay keeps the target silent
  // Counting goes on after the identity bits vanish, so a late answer can land inside the abort wait
  always @(posedge mclk)
  begin
    if (!rst_n || free)
    begin
      // Released bus: pull-ups leave BSY negated
      bsy_in <= 1'b0;
      cnt <= 16'h0000;
      armed <= 1'b0;
    end
    else if (sel_oe && !bsy_in)
    begin
      if (data_oe && data_out[my_id])
        armed <= 1'b1;
      cnt <= cnt + 16'h0001;
      // Target takes the bus by asserting BSY
      if (armed && delay != 16'h0000 && cnt >= delay)
        bsy_in <= 1'b1;
    end
    else if (!sel_oe && !bsy_in)
    begin
      // No selection pending: start afresh
      cnt <= 16'h0000;
      armed <= 1'b0;
    end
  end
endmodule : sccs_bus_model

/* File: verif/tb_scsi_control_command_sequencer.sv */
`timescale 1ns/1ps
`include "sccs_map.svh"
// Self-checking bench for the command sequencer
module tb_scsi_control_command_sequencer;
  localparam int ABORT_CYC = 50; // Short abort wait keeps the run brief
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic hardware_reset_pin = 1'b1; // Active low pin, idle high
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic sel_in = 1'b0; // Another party selecting us
  logic arb_lost = 1'b0; // Holds off arbitration win
  logic msg_out_last_byte = 1'b0;
  logic identify_sent = 1'b0;
  logic held_ack_event = 1'b0;
  logic host_parity_err = 1'b0;
  logic sel_xfer_active = 1'b0;
  logic xfer_byte_done = 1'b0; // Byte finished by the transfer logic
  logic free = 1'b1; // Far side releases the bus
  logic [15:0] model_delay = 16'h0000;
  logic bsy_in, irq, bsy_oe, sel_oe, atn_oe, ack_oe, data_oe, transfer_request_line;
  logic [7:0] rdata, data_out;
  int n_errors = 0;
  int cmp_count = 0;

  // Free-running 100 MHz clock
  always #5 mclk = ~mclk;

  sccs_sequencer #(.ABORT_WAIT_CYC(ABORT_CYC)) dut_u (.mclk(mclk), .rst_n(rst_n),
    .hardware_reset_pin(hardware_reset_pin), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .bsy_in(bsy_in), .sel_in(sel_in), .arb_lost(arb_lost),
    .msg_out_last_byte(msg_out_last_byte), .identify_sent(identify_sent), .held_ack_event(held_ack_event),
    .host_parity_err(host_parity_err), .xfer_byte_done(xfer_byte_done), .sel_xfer_active(sel_xfer_active),
    .fifo_empty(1'b1), .bsy_oe(bsy_oe), .sel_oe(sel_oe), .atn_oe(atn_oe), .ack_oe(ack_oe),
    .data_out(data_out), .data_oe(data_oe), .transfer_request_line(transfer_request_line));

  // Target sits at bus identity 2
  sccs_bus_model model_u (.mclk(mclk), .rst_n(rst_n), .sel_oe(sel_oe), .data_oe(data_oe),
    .data_out(data_out), .my_id(3'h2), .delay(model_delay), .free(free), .bsy_in(bsy_in));

  // Compare and count; unknowns never match
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Print counts and verdict, then stop
  task automatic summarize;
    $display("comparisons=%0d mismatches=%0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize

  // One-cycle register write
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg

  // One-cycle read; data stands only in the following cycle
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  task automatic cmd(input logic [7:0] op);
    wr_reg(`SCCS_ADDR_COMMAND, op);
  endtask : cmd

  // Let n edges pass, then look just after the last one
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : settle

  // One-cycle pulse on transfer-logic events, bits: last byte, identify, held ACK, host parity, byte done
  task automatic pulse(input logic [4:0] m);
    @(posedge mclk);
    {msg_out_last_byte, identify_sent, held_ack_event, host_parity_err, xfer_byte_done} <= m;
    @(posedge mclk);
    {msg_out_last_byte, identify_sent, held_ack_event, host_parity_err, xfer_byte_done} <= 5'h00;
  endtask : pulse

  // Bounded wait for irq, or sel_oe when on_sel is set; running out ends the run
  task automatic wait_hi(input bit on_sel, input int n);
    int i;
    i = 0;
    while ((on_sel ? sel_oe : irq) !== 1'b1 && i < n)
    begin
      settle(1);
      i++;
    end
    if ((on_sel ? sel_oe : irq) !== 1'b1)
    begin
      check(on_sel ? sel_oe : irq, 1'b1);
      summarize();
    end
  endtask : wait_hi

  // Wait for the interrupt and read the status code, which also clears it
  task automatic expect_status(input logic [7:0] code, input int n);
    logic [7:0] d;
    wait_hi(1'b0, n);
    rd_reg(`SCCS_ADDR_STATUS, d);
    check(d, code);
  endtask : expect_status

  // Defaults, hardware pin, software reset codes, refused immediate opcodes
  task automatic t_reset;
    logic [7:0] d;
    logic [7:0] ops [3] = '{`SCCS_OP_ASSERT_ATN, `SCCS_OP_NEGATE_ACK, `SCCS_OP_DISCONNECT};
    check({1'b0, bsy_oe, sel_oe, atn_oe, ack_oe, data_oe, irq, transfer_request_line}, 8'h00);
    rd_reg(`SCCS_ADDR_TIMEOUT, d);
    check(d, `SCCS_TIMEOUT_RST);
    wr_reg(`SCCS_ADDR_CONTROL, 8'h02);
    @(posedge mclk);
    hardware_reset_pin <= 1'b0;
    @(posedge mclk);
    hardware_reset_pin <= 1'b1;
    rd_reg(`SCCS_ADDR_CONTROL, d);
    check(d, `SCCS_CONTROL_RST);
    wr_reg(`SCCS_ADDR_OWN_BUS_IDENTITY_REGISTER, 8'h07);
    cmd(`SCCS_OP_RESET);
    expect_status(`SCCS_ST_RESET, 20);
    wr_reg(`SCCS_ADDR_OWN_BUS_IDENTITY_REGISTER, 8'h0f);
    cmd(`SCCS_OP_RESET);
    expect_status(`SCCS_ST_RESET_ADV, 20);
    // Opcodes that are not valid while disconnected
    foreach (ops[i])
    begin
      cmd(ops[i]);
      settle(4);
      check({5'h00, irq, atn_oe, ack_oe}, 8'h00);
    end
    $display("done: reset");
  endtask : t_reset

  // Abort and outside selection before the arbitration win, reset mid-command
  task automatic t_arb;
    logic [7:0] d;
    arb_lost <= 1'b1;
    cmd(`SCCS_OP_SEL_ATN);
    settle(5);
    cmd(`SCCS_OP_ABORT);
    expect_status(`SCCS_ST_PAUSED, 20);
    check({5'h00, sel_oe, bsy_oe, data_oe}, 8'h00);
    cmd(`SCCS_OP_SEL_ATN);
    settle(5);
    sel_in <= 1'b1;
    wait_hi(1'b0, 20);
    sel_in <= 1'b0;
    rd_reg(`SCCS_ADDR_STATUS, d);
    check(d & 8'hf0, `SCCS_ST_SVC_REQ);
    cmd(`SCCS_OP_SEL_ATN);
    settle(5);
    cmd(`SCCS_OP_RESET);
    expect_status(`SCCS_ST_RESET_ADV, 20);
    check({6'h00, bsy_oe, data_oe}, 8'h00);
    arb_lost <= 1'b0;
    $display("done: arbitration");
  endtask : t_arb

  // Prompt selection, then attention, acknowledge and disconnect as initiator
  task automatic t_sel_ok;
    logic [7:0] d;
    model_delay <= 16'h0005;
    free <= 1'b0;
    wr_reg(`SCCS_ADDR_TARGET_ID, 8'h02);
    wr_reg(`SCCS_ADDR_XFER_CNT, 8'h05);
    wr_reg(`SCCS_ADDR_TIMEOUT, 8'h01);
    cmd(`SCCS_OP_SEL_ATN);
    settle(3);
    check({5'h00, bsy_oe, sel_oe, data_oe}, 8'h05);
    check(data_out, 8'h80);
    wait_hi(1'b1, 60);
    settle(1);
    check({5'h00, bsy_oe, atn_oe, data_oe}, 8'h03);
    check(data_out, 8'h84);
    expect_status(`SCCS_ST_SEL_OK, 40);
    check({6'h00, sel_oe, atn_oe}, 8'h01);
    pulse(5'h08);
    settle(2);
    check(atn_oe, 1'b0);
    cmd(`SCCS_OP_ASSERT_ATN);
    settle(3);
    check(atn_oe, 1'b1);
    pulse(5'h10);
    settle(2);
    check(atn_oe, 1'b0);
    pulse(5'h04);
    settle(2);
    check(ack_oe, 1'b1);
    // Host parity error on a finished byte leaves ACK held
    pulse(5'h03);
    settle(2);
    check(ack_oe, 1'b1);
    // A clean byte drops ACK by itself; two bytes are now off the count
    pulse(5'h01);
    settle(2);
    check(ack_oe, 1'b0);
    rd_reg(`SCCS_ADDR_XFER_CNT, d);
    check(d, 8'h03);
    pulse(5'h04);
    settle(2);
    check(ack_oe, 1'b1);
    cmd(`SCCS_OP_NEGATE_ACK);
    settle(3);
    check(ack_oe, 1'b0);
    sel_xfer_active <= 1'b1;
    cmd(`SCCS_OP_SET_IDI);
    rd_reg(`SCCS_ADDR_CONTROL, d);
    check({7'h00, d[`SCCS_CTRL_IDI_BIT]}, 8'h01);
    sel_xfer_active <= 1'b0;
    // Abort is not valid as initiator
    cmd(`SCCS_OP_ABORT);
    settle(4);
    check({6'h00, irq, sel_oe}, 8'h00);
    cmd(`SCCS_OP_DISCONNECT);
    settle(3);
    check({3'h0, bsy_oe, sel_oe, atn_oe, ack_oe, data_oe}, 8'h00);
    free <= 1'b1;
    // Now disconnected, so attention is refused
    cmd(`SCCS_OP_ASSERT_ATN);
    settle(3);
    check({6'h00, irq, atn_oe}, 8'h00);
    $display("done: select");
  endtask : t_sel_ok

  // Abort after the win with timeout off; target silent or answering late
  task automatic t_abort_win(input logic [15:0] dly, input logic [7:0] code);
    model_delay <= dly;
    free <= 1'b0;
    wr_reg(`SCCS_ADDR_TIMEOUT, 8'h00);
    cmd(`SCCS_OP_SEL_ATN);
    wait_hi(1'b1, 60);
    cmd(`SCCS_OP_ABORT);
    settle(3);
    // Sequencer raises no data request once the abort is written
    check(transfer_request_line, 1'b0);
    check({6'h00, sel_oe, (data_oe !== 1'b1) || (data_out === 8'h00)}, 8'h03);
    expect_status(code, ABORT_CYC + 40);
    check({7'h00, sel_oe}, 8'h00);
    cmd(`SCCS_OP_DISCONNECT);
    free <= 1'b1;
    settle(2);
    $display("done: abort after win");
  endtask : t_abort_win

  // Selection timeout of one period unit, then the abort sequence
  task automatic t_timeout;
    model_delay <= 16'h0000;
    free <= 1'b0;
    wr_reg(`SCCS_ADDR_TIMEOUT, 8'h01);
    cmd(`SCCS_OP_SEL_ATN);
    wait_hi(1'b1, 60);
    settle(`SCCS_TIMEOUT_UNIT_CYC + 10);
    check({6'h00, sel_oe, (data_oe !== 1'b1) || (data_out === 8'h00)}, 8'h03);
    expect_status(`SCCS_ST_TERMINATED, 200);
    check({5'h00, sel_oe, bsy_oe, data_oe}, 8'h00);
    free <= 1'b1;
    $display("done: timeout");
  endtask : t_timeout

  // Main sequence: reset for 8 cycles, then every scenario
  initial
  begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_arb();
    t_sel_ok();
    t_abort_win(16'h0000, `SCCS_ST_PAUSED);
    t_abort_win(16'h0014, `SCCS_ST_SEL_OK);
    t_timeout();
    summarize();
  end
endmodule : tb_scsi_control_command_sequencer
